// [design/status_pin_source_select.sv]
// Status pin A source selector with APB register access.
// Assumes divider pulse inputs and indications are synchronous to pclk.
`timescale 1ns/1ps
module status_pin_source_select
(
    input  wire logic        pclk,              // APB clock
    input  wire logic        presetn,           // Async reset, low
    input  wire logic        psel,              // APB select
    input  wire logic        penable,           // APB access phase
    input  wire logic        pwrite,            // APB direction
    input  wire logic [11:0] paddr,             // APB byte address
    input  wire logic [31:0] pwdata,            // APB write data
    output logic      [31:0] prdata,            // APB read data
    output logic             pready,            // APB ready
    output logic             pslverr,           // APB error
    input  wire logic        primary_reference_los,   // Primary LOSS_OF_SIGNAL
    input  wire logic        secondary_reference_los, // Secondary LOSS_OF_SIGNAL
    input  wire logic [1:0]  pll_loss_of_lock,  // Per PLL lock loss
    input  wire logic [1:0]  pll_r_tick,        // R divider pulses
    input  wire logic [1:0]  pll_r_bypass,      // R divider bypassed
    input  wire logic [1:0]  pll_n_tick,        // N divider pulses
    input  wire logic [1:0]  pll_m_tick,        // M divider pulses
    input  wire logic [1:0]  pll_m_bypass,      // M divider bypassed
    input  wire logic [1:0]  pll_vco_cal,       // VCO calibration busy
    input  wire logic        interrupt_summary, // From flag register
    input  wire logic        eeprom_active,     // EEPROM access busy
    input  wire logic [1:0]  pll_auto_switch,   // Sec-to-pri switch
    input  wire logic        test_override,     // Test claims pin
    input  wire logic        test_level,        // Pin level in test
    input  wire logic        image_load,        // One-cycle image strobe
    input  wire logic [7:0]  image_config,      // Image config byte
    output logic             status_pin_a,      // Status pin A
    output logic             irq                // Interrupt, high
);

    // All block state in one struct
    typedef struct packed {
        logic [3:0]  sel;       // Source selector
        logic        pol;       // Output polarity
        logic [5:0]  half;      // Toggles: R1 R2 N1 N2 M1 M2
        logic        pin;       // Registered pin level
        logic [1:0]  sts;       // Sticky interrupt status
        logic [1:0]  msk;       // Interrupt mask
        logic        irq;       // Registered interrupt
        logic [31:0] rdata;     // Read data
        logic        ready;     // Access phase answer
        logic        err;       // Unmapped access
    } state_t;

    state_t s_q;
    state_t s_d;

    // Address decode, used for both read and write paths
    function automatic logic is_addr(input logic [11:0] a,
                                     input logic [11:0] r);
        return a == r;
    endfunction

    logic        access;      // Access phase, first cycle
    logic        mapped;      // Address hits a register
    logic        raw;         // Selected indication, true level
    logic [5:0]  ticks;       // Divider pulses in toggle order
    logic [1:0]  ev;          // Events this cycle
    logic        cfg_wr;      // Config register written

    assign ticks = {pll_m_tick, pll_n_tick, pll_r_tick};

    // Next state
    always_comb
    begin
        s_d    = s_q;
        access = psel && penable && !s_q.ready;
        mapped = is_addr(paddr, status_pin_pkg::CFG_ADDR)
              || is_addr(paddr, status_pin_pkg::IRQ_STATUS_ADDR)
              || is_addr(paddr, status_pin_pkg::IRQ_MASK_ADDR);
        cfg_wr = access && pwrite
              && is_addr(paddr, status_pin_pkg::CFG_ADDR);
        // Divide-by-two toggles for divider outputs
        for (int i = 0; i < 6; i++)
        begin
            if (ticks[i])
            begin
                s_d.half[i] = !s_q.half[i];
            end
        end
        // Source multiplexer
        unique case (s_q.sel)
            status_pin_pkg::SRC_PRI_LOS:     raw = primary_reference_los;
            status_pin_pkg::SRC_SEC_LOS:     raw = secondary_reference_los;
            status_pin_pkg::SRC_PLL1_LOL:    raw = pll_loss_of_lock[0];
            status_pin_pkg::SRC_PLL2_LOL:    raw = pll_loss_of_lock[1];
            // Bypassed R divider has no halved output: hold low
            status_pin_pkg::SRC_PLL1_R:      raw = s_q.half[0] && !pll_r_bypass[0];
            status_pin_pkg::SRC_PLL2_R:      raw = s_q.half[1] && !pll_r_bypass[1];
            status_pin_pkg::SRC_PLL1_N:      raw = s_q.half[2];
            status_pin_pkg::SRC_PLL2_N:      raw = s_q.half[3];
            status_pin_pkg::SRC_PLL1_CAL:    raw = pll_vco_cal[0];
            status_pin_pkg::SRC_PLL2_CAL:    raw = pll_vco_cal[1];
            status_pin_pkg::SRC_INTERRUPT_SUMMARY:        raw = interrupt_summary;
            status_pin_pkg::SRC_PLL1_M:      raw = s_q.half[4] && !pll_m_bypass[0];
            status_pin_pkg::SRC_PLL2_M:      raw = s_q.half[5] && !pll_m_bypass[1];
            status_pin_pkg::SRC_EEPROM:      raw = eeprom_active;
            status_pin_pkg::SRC_PLL1_SWITCH: raw = pll_auto_switch[0];
            status_pin_pkg::SRC_PLL2_SWITCH: raw = pll_auto_switch[1];
        endcase
        // Test settings win; polarity applies only in normal use
        if (test_override)
        begin
            s_d.pin = test_level;
        end
        else
        begin
            s_d.pin = s_q.pol ? raw : !raw;
        end
        // Events: pin level rose, config written
        ev = {cfg_wr, s_d.pin && !s_q.pin};
        // APB answer: registered, pready one cycle after the access phase starts
        s_d.ready = access;
        s_d.err   = access && !mapped;
        s_d.rdata = 32'h0000_0000;
        if (access && !pwrite)
        begin
            if (is_addr(paddr, status_pin_pkg::CFG_ADDR))
            begin
                // Reserved bits 2:0 read as zero
                s_d.rdata[status_pin_pkg::SEL_LSB +: 4] = s_q.sel;
                s_d.rdata[status_pin_pkg::POL_BIT] = s_q.pol;
            end
            else if (is_addr(paddr, status_pin_pkg::IRQ_STATUS_ADDR))
            begin
                s_d.rdata[1:0] = s_q.sts;
            end
            else if (is_addr(paddr, status_pin_pkg::IRQ_MASK_ADDR))
            begin
                s_d.rdata[1:0] = s_q.msk;
            end
        end
        // Read clears status; a same-cycle event still sets
        if (access && !pwrite
            && is_addr(paddr, status_pin_pkg::IRQ_STATUS_ADDR))
        begin
            s_d.sts = ev;
        end
        else
        begin
            s_d.sts = s_q.sts | ev;
        end
        // Register writes; config bits 2:0 are dropped
        if (cfg_wr)
        begin
            s_d.sel = pwdata[status_pin_pkg::SEL_LSB +: 4];
            s_d.pol = pwdata[status_pin_pkg::POL_BIT];
        end
        else if (image_load)
        begin
            // Image overrides reset values at startup
            s_d.sel = image_config[status_pin_pkg::SEL_LSB +: 4];
            s_d.pol = image_config[status_pin_pkg::POL_BIT];
        end
        if (access && pwrite
            && is_addr(paddr, status_pin_pkg::IRQ_MASK_ADDR))
        begin
            s_d.msk = pwdata[1:0];
        end
        s_d.irq = |(s_d.sts & s_d.msk);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q       <= '0;
            s_q.sel   <= status_pin_pkg::SEL_RESET;
            s_q.pol   <= status_pin_pkg::POL_RESET;
            s_q.msk   <= status_pin_pkg::IRQ_MASK_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign prdata       = s_q.rdata;
    assign pready       = s_q.ready;
    assign pslverr      = s_q.err;
    assign status_pin_a = s_q.pin;
    assign irq          = s_q.irq;

endmodule

// [design/status_pin_pkg.sv]
// Package for the status pin source selector block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package status_pin_pkg;
    // Printed offset 0x1B is not a multiple of four: it is an index
    localparam logic [7:0]  CFG_INDEX        = 8'h1B;
    localparam logic [11:0] CFG_ADDR         = 12'h06C;
    localparam logic [11:0] IRQ_STATUS_ADDR  = 12'h100;
    localparam logic [11:0] IRQ_MASK_ADDR    = 12'h104;
    // Field layout of the config register
    localparam int          SEL_LSB          = 4;
    localparam int          POL_BIT          = 3;
    localparam logic [3:0]  SEL_RESET        = 4'h5;
    localparam logic        POL_RESET        = 1'b1;
    // Selector codes
    localparam logic [3:0]  SRC_PRI_LOS      = 4'h0;
    localparam logic [3:0]  SRC_SEC_LOS      = 4'h1;
    localparam logic [3:0]  SRC_PLL1_LOL     = 4'h2;
    localparam logic [3:0]  SRC_PLL1_R       = 4'h3;
    localparam logic [3:0]  SRC_PLL1_N       = 4'h4;
    localparam logic [3:0]  SRC_PLL2_LOL     = 4'h5;
    localparam logic [3:0]  SRC_PLL2_R       = 4'h6;
    localparam logic [3:0]  SRC_PLL2_N       = 4'h7;
    localparam logic [3:0]  SRC_PLL1_CAL     = 4'h8;
    localparam logic [3:0]  SRC_PLL2_CAL     = 4'h9;
    localparam logic [3:0]  SRC_INTERRUPT_SUMMARY         = 4'hA;
    localparam logic [3:0]  SRC_PLL1_M       = 4'hB;
    localparam logic [3:0]  SRC_PLL2_M       = 4'hC;
    localparam logic [3:0]  SRC_EEPROM       = 4'hD;
    localparam logic [3:0]  SRC_PLL1_SWITCH  = 4'hE;
    localparam logic [3:0]  SRC_PLL2_SWITCH  = 4'hF;
    // Interrupt status bits: 0 pin level rose, 1 config written
    localparam int          IRQ_W            = 2;
    localparam logic [1:0]  IRQ_MASK_RESET   = 2'h0;
endpackage

// [testbench/status_pin_monitor.sv]
// Port checker for the status pin selector.
// Sees only top ports; bound below to every instance.
`timescale 1ns/1ps
module status_pin_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        test_override,
    input wire logic        test_level,
    input wire logic        status_pin_a
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Address decode for the config and irq words
    wire cfg = paddr == status_pin_pkg::CFG_ADDR;
    wire irw = paddr == status_pin_pkg::IRQ_STATUS_ADDR ||
               paddr == status_pin_pkg::IRQ_MASK_ADDR;
    test_wins_a: assert property (test_override |=>
        status_pin_a == $past(test_level)) else $error("override lost");
    ready_timing_a: assert property (psel && penable && !pready |=>
        pready) else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    idle_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    cfg_reserved_a: assert property (pready && !pwrite && cfg |->
        prdata[2:0] == 3'h0 && prdata[31:8] == 24'h0) else $error("rsvd");
    cfg_okay_a: assert property (pready && cfg |-> !pslverr)
        else $error("config refused");
    unmapped_err_a: assert property (pready && !cfg && !irw |->
        pslverr && prdata == 32'h0) else $error("unmapped accepted");
endmodule
bind status_pin_source_select status_pin_monitor mon (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .test_override, .test_level, .status_pin_a);

// [testbench/status_pin_watcher.sv]
// Board logic that watches status pin A.
// Assumes the pin is sampled on the block clock.
`timescale 1ns/1ps
module status_pin_watcher (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        status_pin_a,
    output logic      [15:0] rises
);
    logic last_q; // Previous pin level
    // Counts rising edges, as a board event counter would
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {rises, last_q} <= '0;
        else
            {rises, last_q} <= {rises + 16'(status_pin_a & ~last_q),
                                status_pin_a};
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the status pin selector.
// Assumes the package and design are compiled first.
`timescale 1ns/1ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic primary_reference_los, secondary_reference_los, strb;
    logic interrupt_summary, eeprom_active, test_override, test_level;
    logic image_load, status_pin_a;
    logic [1:0] pll_loss_of_lock, pll_r_tick, pll_r_bypass, pll_n_tick;
    logic [1:0] pll_m_tick, pll_m_bypass, pll_vco_cal, pll_auto_switch;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, s, r;
    logic [7:0] image_config;
    logic [13:0] lv;      // All level indications
    logic [5:0] tk, tg;   // Divider ticks and their halved copies
    logic [15:0] sv;      // Expected source per selector code
    logic [32:0] qr[$];   // Expected {pslverr, prdata}
    logic [1:0] qp[$];    // Expected {irq, pin}
    int n_mismatch = 0;
    int n_checks = 0;
    localparam logic [11:0] CFG = status_pin_pkg::CFG_ADDR;
    status_pin_source_select DUT (.*);
    status_pin_watcher board (.pclk, .presetn, .status_pin_a, .rises());
    assign {pll_auto_switch, eeprom_active, interrupt_summary, pll_vco_cal,
            pll_m_bypass, pll_r_bypass, pll_loss_of_lock,
            secondary_reference_los, primary_reference_los} = lv;
    assign {pll_m_tick, pll_n_tick, pll_r_tick} = tk;
    initial
    begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    function automatic logic [31:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic cmp_rd(input logic [32:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("FAIL read exp %h got %h", e, g);
        end
    endtask
    task automatic cmp_pin(input logic [1:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("FAIL irq_pin exp %h got %h", e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Full APB transfer; holds the request until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        if (!w)
            qr.push_back(e);
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask
    // Lets inputs settle through the pin register, then asks a compare
    task automatic pin_chk(input logic [1:0] e);
        repeat (3) @(posedge pclk);
        qp.push_back(e);
        strb <= 1'h1;
        @(posedge pclk);
        strb <= 1'h0;
    endtask
    // Result watcher: oldest note against what appears
    always @(posedge pclk)
    begin
        if (pready && !pwrite)
            cmp_rd(qr.pop_front(), {pslverr, prdata});
        if (strb)
            cmp_pin(qp.pop_front(), {irq, status_pin_a});
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, strb, lv, tk, tg} = '0;
        {test_override, test_level, image_load, image_config} = '0;
        s = 32'h0000005B;
        presetn = 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, CFG, 32'h0, 33'h58);
        lv <= 14'h0008;
        pin_chk(2'h1);
        lv <= 14'h0;
        apb(1'h1, 12'h104, 32'h2, 33'h0);
        apb(1'h1, CFG, 32'h5F, 33'h0);
        apb(1'h0, CFG, 32'h0, 33'h58);
        pin_chk(2'h2);
        apb(1'h0, 12'h100, 32'h0, 33'h3);
        pin_chk(2'h0);
        apb(1'h1, 12'h104, 32'h0, 33'h0);
        apb(1'h0, 12'h0F0, 32'h0, 33'h100000000);
        {image_load, image_config} <= 9'h1D0;
        @(posedge pclk);
        image_load <= 1'h0;
        apb(1'h0, CFG, 32'h0, 33'hD0);
        // Every code, random polarity, levels, ticks and test claims
        for (int i = 0; i < 48; i++)
        begin
            r = xs();
            apb(1'h1, CFG, {24'h0, i[3:0], r[23], 3'h0}, 33'h0);
            {tk, lv, test_override, test_level} <=
                {r[19:0], &r[21:20], r[22]};
            @(posedge pclk);
            tk <= 6'h0;
            tg = tg ^ r[19:14];
            sv = {r[13:11], ~r[7] & tg[5], ~r[6] & tg[4], r[10:8], tg[3],
                  ~r[5] & tg[1], r[3], tg[2], ~r[4] & tg[0], r[2:0]};
            pin_chk({1'h0, &r[21:20] ? r[22] : sv[i[3:0]] ^ !r[23]});
        end
        final_report();
    end
    // Hang guard
    initial
    begin
        repeat (3000) @(posedge pclk);
        n_mismatch++;
        final_report();
    end
endmodule
